// ### design/cies_core.sv
// Execute stage for a subset of a 14-bit instruction set.
// Assumes the fetch unit presents insn with insn_valid; file data is
// read combinationally at file_addr; stack_top is valid when returning.
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps

module cies_core
(
    input wire logic clk,
    input wire logic reset,
    input wire logic insn_valid,
    input wire logic [13:0] insn,
    input wire logic [7:0] stack_top,
    input wire logic [7:0] file_rdata,
    input wire logic wake,
    output logic [6:0] file_addr,
    output logic [7:0] file_wdata,
    output logic file_we,
    output logic stack_pop,
    output logic [12:0] pc,
    output logic [7:0] acc,
    output logic carry_flag,
    output logic digit_carry_flag,
    output logic zero_flag,
    output logic timeout_flag,
    output logic powerdown_flag,
    output logic global_irq_enable,
    output logic [7:0] watchdog_counter,
    output logic [7:0] wdt_prescaler,
    output logic halted,
    output logic osc_stop,
    output logic insn_ready
);
    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    cies_alu_if alu_bus();
    wire [5:0] op6 = insn[13:8];
    wire dest_select = insn[7];
    wire is_ldl = insn[13:10] == cies_pkg::OP_LDL_HI;
    wire is_retl = insn[13:10] == cies_pkg::OP_RETL_HI;
    wire is_subl = insn[13:9] == cies_pkg::OP_SUBL_HI;
    wire is_xorl = insn[13:8] == {cies_pkg::OP_XORL_HI, 1'b0};
    wire is_store = insn[13:7] == cies_pkg::OP_STORE_HI;
    wire is_ret = insn == cies_pkg::OP_RET;
    wire is_reti = insn == cies_pkg::OP_RETI;
    wire is_sleep = insn == cies_pkg::OP_SLEEP;
    wire is_subf = op6 == cies_pkg::OP_SUBF;
    wire is_xorf = op6 == cies_pkg::OP_XORF;
    wire is_rlc = op6 == cies_pkg::OP_RLC;
    wire is_rrc = op6 == cies_pkg::OP_RRC;
    wire is_swap = op6 == cies_pkg::OP_SWAP;
    wire is_fileop = is_subf | is_xorf | is_rlc | is_rrc | is_swap;
    wire is_return = is_ret | is_reti | is_retl;
    wire upd_z = is_subl | is_subf | is_xorl | is_xorf;
    wire upd_cdc = is_subl | is_subf;
    wire upd_c = is_rlc | is_rrc;

    cies_pkg::cies_state_e state_reg;
    cies_pkg::cies_state_e state_next;
    wire take = insn_valid && state_reg == cies_pkg::CIES_RUN;

    // Datapath hookup
    assign alu_bus.insn = insn;
    assign alu_bus.acc = acc;
    assign alu_bus.file_val = file_rdata;
    assign alu_bus.carry_in = carry_flag;

    cies_alu u_alu
    (
        .bus(alu_bus.alu)
    );

    // ---------------------------------------------------------------
    // Handshake and file port
    // ---------------------------------------------------------------
    assign insn_ready = state_reg == cies_pkg::CIES_RUN;
    assign file_addr = insn[6:0];
    assign file_we = take && (is_store || (is_fileop && dest_select));
    assign file_wdata = is_store ? acc : alu_bus.result;
    assign stack_pop = take && is_return;
    assign halted = state_reg == cies_pkg::CIES_HALT;
    assign osc_stop = halted;

    // Sequencer: returns spend a flush cycle, sleep halts until wake
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            cies_pkg::CIES_RUN:
                if (take && is_return)
                    state_next = cies_pkg::CIES_FLUSH;
                else if (take && is_sleep)
                    state_next = cies_pkg::CIES_HALT;
            cies_pkg::CIES_FLUSH: state_next = cies_pkg::CIES_RUN;
            cies_pkg::CIES_HALT:
                if (wake)
                    state_next = cies_pkg::CIES_RUN;
        endcase
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (reset)
            state_reg <= cies_pkg::CIES_RUN;
        else
            state_reg <= state_next;
    end

    // Program counter: jump to stack top on return, else step
    always_ff @(posedge clk)
    begin
        if (reset)
            pc <= cies_pkg::PC_RST;
        else if (take && is_return)
            pc <= {5'h00, stack_top};
        else if (take)
            pc <= pc + 13'h0001;
    end

    // Accumulator
    always_ff @(posedge clk)
    begin
        if (reset)
            acc <= cies_pkg::ACC_RST;
        else if (take && (is_ldl || is_retl))
            acc <= insn[7:0];
        else if (take && (is_subl || is_xorl))
            acc <= alu_bus.result;
        else if (take && is_fileop && !dest_select)
            acc <= alu_bus.result;
    end

    // Arithmetic flags
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            carry_flag <= 1'b0;
            digit_carry_flag <= 1'b0;
            zero_flag <= 1'b0;
        end
        else if (take)
        begin
            if (upd_c || upd_cdc)
                carry_flag <= alu_bus.carry_out;
            if (upd_cdc)
                digit_carry_flag <= alu_bus.dc_out;
            if (upd_z)
                zero_flag <= alu_bus.zero_out;
        end
    end

    // Interrupt enable, power flags and watchdog clear
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            global_irq_enable <= 1'b0;
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b1;
            watchdog_counter <= cies_pkg::WDT_CLEAR;
            wdt_prescaler <= cies_pkg::WDT_CLEAR;
        end
        else if (take && is_reti)
            global_irq_enable <= 1'b1;
        else if (take && is_sleep)
        begin
            watchdog_counter <= cies_pkg::WDT_CLEAR;
            wdt_prescaler <= cies_pkg::WDT_CLEAR;
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    sequence s_ret_taken;
        take && is_return;
    endsequence

    property p_ldl;
        @(posedge clk) disable iff (reset)
        take && is_ldl |=> acc == $past(insn[7:0]) &&
            $stable(zero_flag) && $stable(carry_flag);
    endproperty
    a_ldl: assert property (p_ldl)
        else $error("literal load wrong");

    property p_reti;
        @(posedge clk) disable iff (reset)
        take && is_reti |=> global_irq_enable &&
            pc == {5'h00, $past(stack_top)} && $stable(zero_flag);
    endproperty
    a_reti: assert property (p_reti)
        else $error("irq return wrong");

    property p_store;
        @(posedge clk) disable iff (reset)
        take && is_store |-> file_we && file_wdata == acc;
    endproperty
    a_store: assert property (p_store)
        else $error("store wrong");

    property p_two_cycle;
        @(posedge clk) disable iff (reset)
        s_ret_taken |=> !insn_ready ##1 insn_ready;
    endproperty
    a_two_cycle: assert property (p_two_cycle)
        else $error("return length");

    property p_retl;
        @(posedge clk) disable iff (reset)
        take && is_retl |=> acc == $past(insn[7:0]) &&
            pc == {5'h00, $past(stack_top)};
    endproperty
    a_retl: assert property (p_retl)
        else $error("literal return wrong");

    property p_rlc;
        @(posedge clk) disable iff (reset)
        take && is_rlc && !dest_select |=>
            acc == {$past(file_rdata[6:0]), $past(carry_flag)} &&
            carry_flag == $past(file_rdata[7]);
    endproperty
    a_rlc: assert property (p_rlc)
        else $error("left rotate wrong");

    property p_rrc;
        @(posedge clk) disable iff (reset)
        take && is_rrc && !dest_select |=>
            acc == {$past(carry_flag), $past(file_rdata[7:1])} &&
            $stable(zero_flag);
    endproperty
    a_rrc: assert property (p_rrc)
        else $error("right rotate wrong");

    property p_sleep;
        @(posedge clk) disable iff (reset)
        take && is_sleep |=> halted && timeout_flag && !powerdown_flag &&
            watchdog_counter == 8'h00 && osc_stop;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep wrong");

    property p_subl;
        @(posedge clk) disable iff (reset)
        take && is_subl |=> acc == 8'($past(insn[7:0]) - $past(acc)) &&
            carry_flag == ($past(insn[7:0]) >= $past(acc)) &&
            zero_flag == (acc == 8'h00);
    endproperty
    a_subl: assert property (p_subl)
        else $error("literal subtract wrong");

    property p_subf;
        @(posedge clk) disable iff (reset)
        take && is_subf && dest_select |-> file_we &&
            file_wdata == 8'(file_rdata - acc) ##1 carry_flag ==
            ($past(file_rdata) >= $past(acc));
    endproperty
    a_subf: assert property (p_subf)
        else $error("file subtract wrong");

    property p_swap;
        @(posedge clk) disable iff (reset)
        take && is_swap && dest_select |-> file_wdata ==
            {file_rdata[3:0], file_rdata[7:4]} ##1 $stable(carry_flag);
    endproperty
    a_swap: assert property (p_swap)
        else $error("swap wrong");

    property p_xorl;
        @(posedge clk) disable iff (reset)
        take && is_xorl |=> acc == ($past(acc) ^ $past(insn[7:0])) &&
            $stable(carry_flag);
    endproperty
    a_xorl: assert property (p_xorl)
        else $error("literal xor wrong");

    property p_xorf;
        @(posedge clk) disable iff (reset)
        take && is_xorf && !dest_select |-> !file_we ##1
            acc == ($past(acc) ^ $past(file_rdata));
    endproperty
    a_xorf: assert property (p_xorf)
        else $error("file xor wrong");

    property p_nop;
        @(posedge clk) disable iff (reset)
        take && insn == cies_pkg::OP_NOP |-> !file_we ##1
            pc == $past(pc) + 13'h0001 && $stable(acc);
    endproperty
    a_nop: assert property (p_nop)
        else $error("no-op changed state");

    property p_rlc_file;
        @(posedge clk) disable iff (reset)
        take && is_rlc && dest_select |-> file_we &&
            file_wdata == {file_rdata[6:0], carry_flag} ##1
            carry_flag == $past(file_rdata[7]) && $stable(zero_flag);
    endproperty
    a_rlc_file: assert property (p_rlc_file)
        else $error("left rotate to file wrong");

    property p_rrc_file;
        @(posedge clk) disable iff (reset)
        take && is_rrc && dest_select |-> file_we &&
            file_wdata == {carry_flag, file_rdata[7:1]} ##1
            carry_flag == $past(file_rdata[0]) && $stable(digit_carry_flag);
    endproperty
    a_rrc_file: assert property (p_rrc_file)
        else $error("right rotate to file wrong");

    property p_swap_acc;
        @(posedge clk) disable iff (reset)
        take && is_swap && !dest_select |-> !file_we ##1
            acc == {$past(file_rdata[3:0]), $past(file_rdata[7:4])} &&
            $stable(zero_flag);
    endproperty
    a_swap_acc: assert property (p_swap_acc)
        else $error("swap to accumulator wrong");

    property p_subf_acc;
        @(posedge clk) disable iff (reset)
        take && is_subf && !dest_select |-> !file_we ##1
            acc == 8'($past(file_rdata) - $past(acc)) &&
            digit_carry_flag ==
            ($past(file_rdata[3:0]) >= $past(acc[3:0]));
    endproperty
    a_subf_acc: assert property (p_subf_acc)
        else $error("file subtract to accumulator wrong");

    property p_xorf_file;
        @(posedge clk) disable iff (reset)
        take && is_xorf && dest_select |-> file_we &&
            file_wdata == (acc ^ file_rdata) ##1
            zero_flag == (($past(acc) ^ $past(file_rdata)) == 8'h00);
    endproperty
    a_xorf_file: assert property (p_xorf_file)
        else $error("file xor to file wrong");

    // Plain return: pop now, jump next cycle, flags and accumulator kept
    sequence s_ret_plain;
        take && is_ret;
    endsequence

    property p_ret;
        @(posedge clk) disable iff (reset)
        s_ret_plain |-> stack_pop ##1 pc == {5'h00, $past(stack_top)} &&
            $stable(carry_flag) && $stable(zero_flag) && $stable(acc);
    endproperty
    a_ret: assert property (p_ret)
        else $error("return wrong");

    property p_halt_hold;
        @(posedge clk) disable iff (reset)
        halted && !wake |=> halted && osc_stop && $stable(pc) &&
            $stable(acc) && !insn_ready;
    endproperty
    a_halt_hold: assert property (p_halt_hold)
        else $error("halt not held");
endmodule

// ### shared/cies_pkg.sv
// Constants, encodings and state types for the instruction execute subset.
// Assumes a 14-bit instruction word presented one per instruction cycle.
// Notes on behaviour
// - Literal load puts the literal in the accumulator; flags kept.
// - Interrupt return loads pc from stack top, sets irq enable.
// - Accumulator store writes the accumulator to the addressed file.
// - Return with literal loads accumulator and pc; two cycles.
// - Left rotate through carry; to accumulator if 0, file if 1.
// - Right rotate through carry; only carry changes; routed by select.
// - Sleep clears watchdog, prescaler, powerdown; sets timeout; halts.
// - Return pops the stack into pc, flags kept, two cycles.
// - Literal minus accumulator to accumulator; carry, digit carry, zero.
// - File minus accumulator routed by select; carry, digit carry, zero.
// - Nibble exchange swaps file halves, routed by select, no flags.
// - Accumulator xor literal to accumulator; only zero flag changes.
// - Accumulator xor file routed by select; only zero flag changes.
// - No operation changes nothing but advances the program counter.

package cies_pkg;
    // ---------------------------------------------------------------
    // Widths
    // ---------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int FILE_W = 7;
    localparam int PC_W = 13;
    localparam int INSN_W = 14;

    // ---------------------------------------------------------------
    // Instruction encodings
    // ---------------------------------------------------------------
    localparam logic [13:0] OP_NOP = 14'h0000;
    localparam logic [13:0] OP_RET = 14'h0008;
    localparam logic [13:0] OP_RETI = 14'h0009;
    localparam logic [13:0] OP_SLEEP = 14'h0063;
    localparam logic [6:0] OP_STORE_HI = 7'h01;
    localparam logic [5:0] OP_SUBF = 6'h02;
    localparam logic [5:0] OP_XORF = 6'h06;
    localparam logic [5:0] OP_RRC = 6'h0C;
    localparam logic [5:0] OP_RLC = 6'h0D;
    localparam logic [5:0] OP_SWAP = 6'h0E;
    localparam logic [3:0] OP_LDL_HI = 4'hC;
    localparam logic [3:0] OP_RETL_HI = 4'hD;
    localparam logic [4:0] OP_XORL_HI = 5'h1D;
    localparam logic [4:0] OP_SUBL_HI = 5'h1E;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] WDT_CLEAR = 8'h00;
    localparam logic [12:0] PC_RST = 13'h0000;

    // ---------------------------------------------------------------
    // Execution states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {CIES_RUN, CIES_FLUSH, CIES_HALT} cies_state_e;
endpackage

// ### shared/cies_alu_if.sv
// Carrier between the sequencer and the datapath unit.
// Assumes one clock domain; all signals are combinational.
`timescale 1ns/1ps

interface cies_alu_if;
    logic [13:0] insn;
    logic [7:0] acc;
    logic [7:0] file_val;
    logic carry_in;
    logic [7:0] result;
    logic carry_out;
    logic dc_out;
    logic zero_out;

    modport ctrl (output insn, output acc, output file_val,
        output carry_in, input result, input carry_out, input dc_out,
        input zero_out);
    modport alu (input insn, input acc, input file_val, input carry_in,
        output result, output carry_out, output dc_out, output zero_out);
endinterface

// ### design/cies_alu.sv
// Combinational datapath for the execute subset.
// Assumes the instruction is already decoded into a single word.
`timescale 1ns/1ps

module cies_alu
(
    cies_alu_if.alu bus
);
    wire [7:0] lit = bus.insn[7:0];
    wire [8:0] sub_l = {1'b0, lit} - {1'b0, bus.acc};
    wire [8:0] sub_f = {1'b0, bus.file_val} - {1'b0, bus.acc};
    wire [4:0] sub_ln = {1'b0, lit[3:0]} - {1'b0, bus.acc[3:0]};
    wire [4:0] sub_fn = {1'b0, bus.file_val[3:0]} - {1'b0, bus.acc[3:0]};
    wire is_subl = bus.insn[13:9] == cies_pkg::OP_SUBL_HI;
    wire is_xorl = bus.insn[13:8] == {cies_pkg::OP_XORL_HI, 1'b0};
    wire [5:0] op6 = bus.insn[13:8];

    // Result and flag selection
    always_comb
    begin
        bus.result = bus.file_val;
        bus.carry_out = bus.carry_in;
        bus.dc_out = 1'b0;
        if (is_subl)
        begin
            bus.result = sub_l[7:0];
            bus.carry_out = ~sub_l[8];
            bus.dc_out = ~sub_ln[4];
        end
        else if (is_xorl)
            bus.result = bus.acc ^ lit;
        else if (bus.insn[13:12] == 2'b00)
        begin
            unique case (op6)
                cies_pkg::OP_SUBF:
                begin
                    bus.result = sub_f[7:0];
                    bus.carry_out = ~sub_f[8];
                    bus.dc_out = ~sub_fn[4];
                end
                cies_pkg::OP_XORF:
                    bus.result = bus.acc ^ bus.file_val;
                cies_pkg::OP_RLC:
                begin
                    bus.result = {bus.file_val[6:0], bus.carry_in};
                    bus.carry_out = bus.file_val[7];
                end
                cies_pkg::OP_RRC:
                begin
                    bus.result = {bus.carry_in, bus.file_val[7:1]};
                    bus.carry_out = bus.file_val[0];
                end
                cies_pkg::OP_SWAP:
                    bus.result = {bus.file_val[3:0],
                        bus.file_val[7:4]};
                default: bus.result = bus.file_val;
            endcase
        end
    end

    assign bus.zero_out = bus.result == 8'h00;
endmodule

// ### sim/test_cies_core.sv
// Self-checking bench for the execute subset core, with a bench model.
// Assumes cies_pkg encodings and a 250 MHz clock with synchronous reset.
`timescale 1ns/1ps

module test_cies_core;
    // ---------------------------------------------------------------
    // Signals and model state
    // ---------------------------------------------------------------
    logic clk, reset, insn_valid, wake;
    logic [13:0] insn;
    logic [7:0] stack_top, file_rdata;
    logic [6:0] file_addr;
    logic [7:0] file_wdata, acc, watchdog_counter, wdt_prescaler;
    logic [12:0] pc;
    logic file_we, stack_pop, carry_flag, digit_carry_flag, zero_flag;
    logic timeout_flag, powerdown_flag, global_irq_enable;
    logic halted, osc_stop, insn_ready;
    int bad_count, samples_checked;
    logic [12:0] m_pc;
    logic [7:0] m_acc;
    bit m_c, m_dc, m_z, m_gie, m_to, m_pd, m_halt, ret_last, pc_known;

    // Device under test
    cies_core dut (.clk(clk), .reset(reset), .insn_valid(insn_valid),
        .insn(insn), .stack_top(stack_top), .file_rdata(file_rdata),
        .wake(wake), .file_addr(file_addr), .file_wdata(file_wdata),
        .file_we(file_we), .stack_pop(stack_pop), .pc(pc), .acc(acc),
        .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag),
        .zero_flag(zero_flag), .timeout_flag(timeout_flag),
        .powerdown_flag(powerdown_flag),
        .global_irq_enable(global_irq_enable),
        .watchdog_counter(watchdog_counter), .wdt_prescaler(wdt_prescaler),
        .halted(halted), .osc_stop(osc_stop), .insn_ready(insn_ready));

    // Free-running clock, 4 ns period
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ---------------------------------------------------------------
    // Compare and report
    // ---------------------------------------------------------------
    task automatic chk_word(input string name, input logic [12:0] e,
        input logic [12:0] g);
        samples_checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic chk_bit(input string name, input logic e, input logic g);
        chk_word(name, {12'h000, e}, {12'h000, g});
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Bench model
    // ---------------------------------------------------------------
    task automatic model_reset;
        m_pc = 13'h0000;
        m_acc = 8'h00;
        {m_c, m_dc, m_z, m_gie, m_halt, ret_last} = 6'h00;
        {m_to, m_pd, pc_known} = 3'h7;
    endtask

    // Subtract flags: carry and digit carry mean no borrow
    task automatic sub_flags(input logic [7:0] x, input logic [7:0] y);
        m_c = (x >= y);
        m_dc = (x[3:0] >= y[3:0]);
        m_z = (x == y);
    endtask

    task automatic model(input logic [13:0] w, input logic [7:0] f,
        input logic [7:0] st, output bit we, output logic [7:0] wd,
        output bit pop);
        logic [7:0] k, a, r;
        int sel;
        k = w[7:0];
        a = m_acc;
        r = 8'h00;
        sel = 0;
        we = 0;
        wd = 8'h00;
        pop = 0;
        m_pc = m_pc + 13'h0001;
        if (w == cies_pkg::OP_RET || w == cies_pkg::OP_RETI)
        begin
            pop = 1;
            m_pc = {5'h00, st};
            if (w == cies_pkg::OP_RETI)
                m_gie = 1;
        end
        else if (w == cies_pkg::OP_SLEEP)
            {m_to, m_pd, m_halt, pc_known} = 4'hA;
        else if (w[13:7] == cies_pkg::OP_STORE_HI)
            {we, wd} = {1'b1, a};
        else if (w[13:10] == cies_pkg::OP_LDL_HI)
            m_acc = k;
        else if (w[13:10] == cies_pkg::OP_RETL_HI)
            {pop, m_acc, m_pc} = {1'b1, k, 5'h00, st};
        else if (w[13:9] == cies_pkg::OP_XORL_HI)
            {r, m_z, sel} = {k ^ a, (k ^ a) == 8'h00, 32'd1};
        else if (w[13:9] == cies_pkg::OP_SUBL_HI)
        begin
            r = k - a;
            sub_flags(k, a);
            sel = 1;
        end
        else if (w[13:8] == cies_pkg::OP_SUBF)
        begin
            r = f - a;
            sub_flags(f, a);
            sel = 2;
        end
        else if (w[13:8] == cies_pkg::OP_XORF)
            {r, m_z, sel} = {f ^ a, (f ^ a) == 8'h00, 32'd2};
        else if (w[13:8] == cies_pkg::OP_RRC)
            {r, m_c, sel} = {m_c, f, 32'd2};
        else if (w[13:8] == cies_pkg::OP_RLC)
            {m_c, r, sel} = {f, m_c, 32'd2};
        else if (w[13:8] == cies_pkg::OP_SWAP)
            {r, sel} = {f[3:0], f[7:4], 32'd2};
        if (sel == 2 && w[7])
            {we, wd} = {1'b1, r};
        else if (sel != 0)
            m_acc = r;
    endtask

    // ---------------------------------------------------------------
    // Drivers
    // ---------------------------------------------------------------
    task automatic tick(input bit r);
        @(posedge clk);
        ret_last = r;
    endtask

    // Registered state against the model, just after an edge
    task automatic check_regs;
        if (pc_known)
            chk_word("pc", m_pc, pc);
        chk_word("acc", 13'(m_acc), 13'(acc));
        chk_bit("carry", m_c, carry_flag);
        chk_bit("digit_carry", m_dc, digit_carry_flag);
        chk_bit("zero", m_z, zero_flag);
        chk_bit("irq_enable", m_gie, global_irq_enable);
        chk_bit("timeout", m_to, timeout_flag);
        chk_bit("powerdown", m_pd, powerdown_flag);
        chk_word("wdt", 13'h0000, 13'(watchdog_counter));
        chk_word("prescaler", 13'h0000, 13'(wdt_prescaler));
        chk_bit("halted", m_halt, halted);
        chk_bit("osc_stop", m_halt, osc_stop);
        chk_bit("ready", !m_halt && !ret_last, insn_ready);
    endtask

    // Issue one instruction, holding it while refused
    task automatic exec(input logic [13:0] w, input logic [7:0] f);
        logic [7:0] st, wd;
        bit we, pop;
        st = 8'($urandom);
        insn <= w;
        insn_valid <= 1'b1;
        file_rdata <= f;
        stack_top <= st;
        #1;
        check_regs();
        if (ret_last)
        begin
            chk_bit("pop_refused", 1'b0, stack_pop);
            tick(1'b0);
            #1;
            check_regs();
        end
        model(w, f, st, we, wd, pop);
        chk_bit("file_we", we, file_we);
        if (we)
            chk_word("wdata", 13'(wd), 13'(file_wdata));
        chk_word("addr", 13'(w[6:0]), 13'(file_addr));
        chk_bit("stack_pop", pop, stack_pop);
        tick(pop);
    endtask

    task automatic idle(input bit v);
        insn_valid <= v;
        #1;
        check_regs();
        chk_bit("stack_pop", 1'b0, stack_pop);
        tick(1'b0);
    endtask

    function automatic logic [13:0] mk(input int sel, input logic [7:0] k,
        input logic [6:0] fa, input logic d);
        case (sel)
            1: mk = cies_pkg::OP_RET;
            2: mk = cies_pkg::OP_RETI;
            3: mk = {cies_pkg::OP_STORE_HI, fa};
            4: mk = {cies_pkg::OP_LDL_HI, 2'b00, k};
            5: mk = {cies_pkg::OP_RETL_HI, 2'b00, k};
            6: mk = {cies_pkg::OP_XORL_HI, 1'b0, k};
            7: mk = {cies_pkg::OP_SUBL_HI, 1'b0, k};
            8: mk = {cies_pkg::OP_SUBF, d, fa};
            9: mk = {cies_pkg::OP_XORF, d, fa};
            10: mk = {cies_pkg::OP_RRC, d, fa};
            11: mk = {cies_pkg::OP_RLC, d, fa};
            12: mk = {cies_pkg::OP_SWAP, d, fa};
            default: mk = cies_pkg::OP_NOP;
        endcase
    endfunction

    task automatic random_run(input int n);
        repeat (n)
        begin
            exec(mk($urandom % 13, 8'($urandom), 7'($urandom),
                1'($urandom)), 8'($urandom));
            if ($urandom % 5 == 0)
                idle(1'b0);
        end
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial
    begin
        {reset, insn_valid, wake} = 3'h4;
        {insn, stack_top, file_rdata} = 30'h00000000;
        bad_count = 0;
        samples_checked = 0;
        void'($urandom(23296));
        model_reset();
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        exec(mk(4, 8'h01, 7'h00, 1'b0), 8'h00);
        exec(mk(7, 8'h00, 7'h00, 1'b0), 8'h00);
        exec(mk(7, 8'hFF, 7'h00, 1'b0), 8'h00);
        for (int s = 0; s < 13; s++)
        begin
            exec(mk(s, 8'hFF, 7'h7F, 1'b1), 8'h80);
            exec(mk(s, 8'h00, 7'h00, 1'b0), 8'h01);
        end
        random_run(400);
        exec(cies_pkg::OP_SLEEP, 8'h00);
        insn <= mk(4, 8'hA5, 7'h00, 1'b0);
        repeat (3) idle(1'b1);
        wake <= 1'b1;
        idle(1'b0);
        wake <= 1'b0;
        m_halt = 0;
        idle(1'b0);
        reset <= 1'b1;
        repeat (12) tick(1'b0);
        reset <= 1'b0;
        model_reset();
        exec(cies_pkg::OP_RET, 8'h00);
        exec(cies_pkg::OP_RETI, 8'h00);
        exec(mk(5, 8'h3C, 7'h00, 1'b0), 8'h00);
        random_run(100);
        idle(1'b0);
        give_verdict();
    end
endmodule
